// [rtl/scwl_pkg.sv]
// constants, field layout and timing shared by both ends of the serial control word loader
// assumes a 250 MHz hclk on both ends and a host-made serial clock
// Functional notes
// - device shifts data on each serial clock rise
// - strobe rise loads word into addressed latch
// - host keeps clock, data low around strobe
// - only last 24 shifted bits are kept
// - 24-bit words, most significant bit first
// - port accepts words active or in standby
// - host sends all four words, or one
// - address 111 is test latch, avoid it
// - test mode cleared by all-zero test word
// - host clears test latch after power-up
// - bits 10-9 amp level, nonzero enables modulation
// - bit 11 oscillator enable, resets zero
// - bit 12 synthesizer loop enable, resets zero
// - mode0 control word is bank0, mode1 bank1
// - bits 21-0 of frequency words are tuning
// - mode0 control bits 20-13 are fsk shift
// - mode1 control bits 20-18 are boost factor
// - mode1 control bit 17 divider 256/512
// - mode1 control bit 16 modulation select, keep 0
// - mode pin switches between the two banks
// - latch contents kept through standby
// - sleep pin low powers blocks down
package scwl_pkg;
   localparam int WORD_W = 24;
   localparam int ADDR_HI = 23;
   localparam int ADDR_LO = 21;
   localparam logic [2:0] ADDR_FREQ0 = 3'h0;
   localparam logic [2:0] ADDR_FREQ1 = 3'h1;
   localparam logic [2:0] ADDR_CTRL1 = 3'h2;
   localparam logic [2:0] ADDR_CTRL0 = 3'h3;
   localparam logic [2:0] ADDR_TEST = 3'h7;
   localparam int TUNE_HI = 21;
   localparam int TUNE_W = 22;
   localparam int AMP_HI = 10;
   localparam int AMP_LO = 9;
   localparam int OSC_BIT = 11;
   localparam int LOOP_BIT = 12;
   localparam int DEV_HI = 20;
   localparam int DEV_LO = 13;
   localparam int ACC_HI = 20;
   localparam int ACC_LO = 18;
   localparam int DIV_BIT = 17;
   localparam int MOD_BIT = 16;
   localparam int TEST_HI = 20;
   localparam logic [WORD_W-1:0] WORD_RST = 24'h000000;
   localparam logic [WORD_W-1:0] TEST_CLEAR_WORD = 24'he00000;
   // timing
   localparam int CLK_MHZ = 250;
   localparam int SCLK_HALF_NS = 32;
   localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
   localparam int STROBE_NS = 64;
   localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
   // host register map
   localparam logic [7:0] REG_WORD = 8'h00;
   localparam logic [7:0] REG_CTRL = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam int CTRL_MODE_BIT = 0;
   localparam int CTRL_WAKE_BIT = 1;
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam int STAT_BUSY_BIT = 0;
   typedef enum logic [2:0] {SCWL_IDLE, SCWL_LOW, SCWL_HIGH, SCWL_PRE, SCWL_STRB, SCWL_POST} scwl_state_t;
endpackage

// [rtl/scwl_if.sv]
// three-wire serial programming link plus mode and sleep pins
// host drives every wire; the device only listens
`timescale 1ns/1ps
interface scwl_if;
   logic sclk;
   logic sdata;
   logic strobe;
   logic mode_pin;
   logic sleep_pin;
   modport dev (input sclk, input sdata, input strobe, input mode_pin, input sleep_pin);
   modport host (output sclk, output sdata, output strobe, output mode_pin, output sleep_pin);
endinterface

// [rtl/scwl_device.sv]
// device end: serial shift register, address-decoded latches, bank selection
// assumes link pins are asynchronous to hclk and the host keeps its side of the link
`timescale 1ns/1ps
module scwl_device
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // link
   scwl_if.dev link,
   // active bank controls
   output logic bank_sel,
   output logic blocks_powered,
   output logic [1:0] amp_level,
   output logic tx_mod_enable,
   output logic oscillator_enable,
   output logic loop_enable,
   output logic [scwl_pkg::TUNE_W-1:0] tuning_value,
   // shared controls
   output logic [scwl_pkg::DEV_HI-scwl_pkg::DEV_LO:0] fsk_shift,
   output logic [scwl_pkg::ACC_HI-scwl_pkg::ACC_LO:0] acquisition_boost_factor,
   output logic feedback_divide_select,
   output logic modulation_select,
   output logic test_mode
);
   import scwl_pkg::*;

   typedef struct packed {
      logic [1:0] sclk_s;
      logic [1:0] data_s;
      logic [1:0] strb_s;
      logic [1:0] mode_s;
      logic [1:0] sleep_s;
      logic sclk_q;
      logic strb_q;
      logic [WORD_W-1:0] shift;
      logic [WORD_W-1:0] freq0;
      logic [WORD_W-1:0] freq1;
      logic [WORD_W-1:0] ctrl0;
      logic [WORD_W-1:0] ctrl1;
      logic [TEST_HI:0] test;
      logic bank;
      logic powered;
      logic [1:0] amp;
      logic mod_en;
      logic osc_en;
      logic loop_en;
      logic [TUNE_W-1:0] tune;
      logic [DEV_HI-DEV_LO:0] dev;
      logic [ACC_HI-ACC_LO:0] acc;
      logic div_sel;
      logic mod_sel;
      logic test_on;
   } scwl_dev_state_t;

   scwl_dev_state_t st_r;
   scwl_dev_state_t st_nxt;
   logic sclk_rise;
   logic strb_rise;
   logic [WORD_W-1:0] sel_ctrl;
   logic [WORD_W-1:0] sel_freq;
   logic awake;

   always_comb
   begin
      st_nxt = st_r;
      // two-stage synchronisers; only the second stage, index 1, is read further on
      st_nxt.sclk_s = {st_r.sclk_s[0], link.sclk};
      st_nxt.data_s = {st_r.data_s[0], link.sdata};
      st_nxt.strb_s = {st_r.strb_s[0], link.strobe};
      st_nxt.mode_s = {st_r.mode_s[0], link.mode_pin};
      st_nxt.sleep_s = {st_r.sleep_s[0], link.sleep_pin};
      st_nxt.sclk_q = st_r.sclk_s[1];
      st_nxt.strb_q = st_r.strb_s[1];
      sclk_rise = st_r.sclk_s[1] & ~st_r.sclk_q;
      strb_rise = st_r.strb_s[1] & ~st_r.strb_q;

      // shifting is independent of the sleep pin
      if (sclk_rise)
      begin
         // first bit ends up at the top; older bits fall off
         st_nxt.shift = {st_r.shift[WORD_W-2:0], st_r.data_s[1]};
      end

      // latches move only here, never while shifting
      if (strb_rise)
      begin
         unique case (st_r.shift[ADDR_HI:ADDR_LO])
            ADDR_FREQ0: st_nxt.freq0 = st_r.shift;
            ADDR_FREQ1: st_nxt.freq1 = st_r.shift;
            ADDR_CTRL1: st_nxt.ctrl1 = st_r.shift;
            ADDR_CTRL0: st_nxt.ctrl0 = st_r.shift;
            ADDR_TEST: st_nxt.test = st_r.shift[TEST_HI:0];
            default: st_nxt.test = st_r.test;
         endcase
      end

      // bank selection follows the mode pin at any time, not tied to the link
      st_nxt.bank = st_r.mode_s[1];
      awake = st_r.sleep_s[1];
      st_nxt.powered = awake;
      sel_ctrl = st_r.mode_s[1] ? st_r.ctrl1 : st_r.ctrl0;
      sel_freq = st_r.mode_s[1] ? st_r.freq1 : st_r.freq0;

      // in standby the enables drop but the latches keep their words
      if (awake)
      begin
         st_nxt.amp = sel_ctrl[AMP_HI:AMP_LO];
         st_nxt.mod_en = |sel_ctrl[AMP_HI:AMP_LO];
         st_nxt.osc_en = sel_ctrl[OSC_BIT];
         st_nxt.loop_en = sel_ctrl[LOOP_BIT];
      end
      else
      begin
         st_nxt.amp = 2'h0;
         st_nxt.mod_en = 1'b0;
         st_nxt.osc_en = 1'b0;
         st_nxt.loop_en = 1'b0;
      end
      st_nxt.tune = sel_freq[TUNE_HI:0];
      st_nxt.dev = st_r.ctrl0[DEV_HI:DEV_LO];
      st_nxt.acc = st_r.ctrl1[ACC_HI:ACC_LO];
      st_nxt.div_sel = st_r.ctrl1[DIV_BIT];
      st_nxt.mod_sel = st_r.ctrl1[MOD_BIT];
      // any nonzero test payload keeps test mode on
      st_nxt.test_on = |st_r.test;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign bank_sel = st_r.bank;
   assign blocks_powered = st_r.powered;
   assign amp_level = st_r.amp;
   assign tx_mod_enable = st_r.mod_en;
   assign oscillator_enable = st_r.osc_en;
   assign loop_enable = st_r.loop_en;
   assign tuning_value = st_r.tune;
   assign fsk_shift = st_r.dev;
   assign acquisition_boost_factor = st_r.acc;
   assign feedback_divide_select = st_r.div_sel;
   assign modulation_select = st_r.mod_sel;
   assign test_mode = st_r.test_on;
endmodule // scwl_device

// [rtl/scwl_host.sv]
// host end: AHB-Lite register slave that serialises 24-bit words onto the link
// assumes a single AHB-Lite master with hready looped back from hreadyout
`timescale 1ns/1ps
module scwl_host
#(
   parameter int HALF_CYC = scwl_pkg::SCLK_HALF_CYC,
   parameter int STRB_CYC = scwl_pkg::STROBE_CYC
)
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic hwrite,
   input wire logic [1:0] htrans,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // link
   scwl_if.host link
);
   import scwl_pkg::*;

   typedef struct packed {
      logic dp_v;
      logic dp_w;
      logic [7:0] dp_a;
      logic [31:0] rdata;
      logic [WORD_W-1:0] last;
      logic [WORD_W-1:0] sh;
      logic [1:0] ctrl;
      scwl_state_t state;
      logic [4:0] bits;
      logic [7:0] cnt;
      logic sclk;
      logic sdata;
      logic strobe;
   } scwl_host_state_t;

   scwl_host_state_t st_r;
   scwl_host_state_t st_nxt;
   logic busy;
   logic stall;

   assign busy = (st_r.state != SCWL_IDLE);
   // a word write waits in its data phase until the previous word is out
   assign stall = st_r.dp_v & st_r.dp_w & (st_r.dp_a == REG_WORD) & busy;

   always_comb
   begin
      st_nxt = st_r;
      if (st_r.dp_v && st_r.dp_w && !stall)
      begin
         unique case (st_r.dp_a)
            REG_WORD:
            begin
               // load the word and put its top bit on the data line
               st_nxt.last = hwdata[WORD_W-1:0];
               st_nxt.sh = hwdata[WORD_W-1:0];
               st_nxt.sdata = hwdata[WORD_W-1];
               st_nxt.sclk = 1'b0;
               st_nxt.bits = 5'h0;
               st_nxt.cnt = 8'h0;
               st_nxt.state = SCWL_LOW;
            end
            REG_CTRL:
            begin
               // mode and sleep pins follow from the next edge
               st_nxt.ctrl = hwdata[1:0];
            end
            default:
            begin
               // status and unmapped offsets ignore writes
               st_nxt.ctrl = st_r.ctrl;
            end
         endcase
      end
      // address phase: capture the request and the read data for its data phase
      if (!stall)
      begin
         st_nxt.dp_v = hsel & htrans[1] & hready;
         st_nxt.dp_w = hwrite;
         st_nxt.dp_a = haddr[7:0];
         unique case (haddr[7:0])
            REG_WORD:
            begin
               st_nxt.rdata = {8'h0, st_r.last};
            end
            REG_CTRL:
            begin
               st_nxt.rdata = {30'h0, st_r.ctrl};
            end
            REG_STATUS:
            begin
               st_nxt.rdata = {31'h0, busy};
            end
            default:
            begin
               // unmapped offsets read as zero
               st_nxt.rdata = 32'h0;
            end
         endcase
      end

      // link sequencer: each bit is a low then a high half period, then the strobe frame
      unique case (st_r.state)
         SCWL_IDLE:
         begin
            // link rests low between words
            st_nxt.strobe = st_r.strobe;
         end
         SCWL_LOW:
         begin
            st_nxt.cnt = st_r.cnt + 8'h1;
            if (st_r.cnt == 8'(HALF_CYC - 1))
            begin
               st_nxt.cnt = 8'h0;
               st_nxt.sclk = 1'b1;
               st_nxt.state = SCWL_HIGH;
            end
         end
         SCWL_HIGH:
         begin
            st_nxt.cnt = st_r.cnt + 8'h1;
            if (st_r.cnt == 8'(HALF_CYC - 1))
            begin
               st_nxt.cnt = 8'h0;
               st_nxt.sclk = 1'b0;
               st_nxt.sh = {st_r.sh[WORD_W-2:0], 1'b0};
               st_nxt.sdata = st_r.sh[WORD_W-2];
               st_nxt.bits = st_r.bits + 5'h1;
               if (st_r.bits == 5'(WORD_W - 1))
               begin
                  st_nxt.sdata = 1'b0;
                  st_nxt.state = SCWL_PRE;
               end
               else
               begin
                  st_nxt.state = SCWL_LOW;
               end
            end
         end
         SCWL_PRE:
         begin
            // last clock low held a half period before the strobe
            st_nxt.sclk = 1'b0;
            st_nxt.sdata = 1'b0;
            st_nxt.cnt = st_r.cnt + 8'h1;
            if (st_r.cnt == 8'(HALF_CYC - 1))
            begin
               st_nxt.cnt = 8'h0;
               st_nxt.strobe = 1'b1;
               st_nxt.state = SCWL_STRB;
            end
         end
         SCWL_STRB:
         begin
            // clock and data stay low for the whole strobe
            st_nxt.sclk = 1'b0;
            st_nxt.sdata = 1'b0;
            st_nxt.cnt = st_r.cnt + 8'h1;
            if (st_r.cnt == 8'(STRB_CYC - 1))
            begin
               st_nxt.cnt = 8'h0;
               st_nxt.strobe = 1'b0;
               st_nxt.state = SCWL_POST;
            end
         end
         SCWL_POST:
         begin
            // link stays quiet a half period before the next word
            st_nxt.sclk = 1'b0;
            st_nxt.sdata = 1'b0;
            st_nxt.cnt = st_r.cnt + 8'h1;
            if (st_r.cnt == 8'(HALF_CYC - 1))
            begin
               st_nxt.cnt = 8'h0;
               st_nxt.state = SCWL_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign hreadyout = ~stall;
   assign hresp = 1'b0;
   assign hrdata = st_r.rdata;
   assign link.sclk = st_r.sclk;
   assign link.sdata = st_r.sdata;
   assign link.strobe = st_r.strobe;
   assign link.mode_pin = st_r.ctrl[CTRL_MODE_BIT];
   assign link.sleep_pin = st_r.ctrl[CTRL_WAKE_BIT];
endmodule // scwl_host

// [testbench/scwl_sva.sv]
// concurrent checks on the serial link between the host and device ends
// assumes the link is sampled in hclk and the counts match the host's parameters
`timescale 1ns/1ps
module scwl_sva
#(
   parameter int HALF_CYC = scwl_pkg::SCLK_HALF_CYC,
   parameter int STRB_CYC = scwl_pkg::STROBE_CYC
)
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // link
   input wire logic sclk,
   input wire logic sdata,
   input wire logic strobe,
   input wire logic mode_pin,
   input wire logic sleep_pin
);
   logic [4:0] bits_r;
   logic [15:0] hi_r;
   logic [15:0] lo_r;
   logic [15:0] st_r;
   logic sclk_d_r;
   logic strobe_d_r;
   // run lengths of clock high, clock low and strobe high, saturating
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         bits_r <= 5'h0;
         hi_r <= 16'h0;
         lo_r <= 16'h0;
         st_r <= 16'h0;
         sclk_d_r <= 1'b0;
         strobe_d_r <= 1'b0;
      end
      else
      begin
         sclk_d_r <= sclk;
         strobe_d_r <= strobe;
         if (strobe && !strobe_d_r)
            bits_r <= 5'h0;
         else if (sclk && !sclk_d_r && bits_r != 5'h1f)
            bits_r <= bits_r + 5'h1;
         hi_r <= sclk ? hi_r + {15'h0, hi_r != 16'hffff} : 16'h0;
         lo_r <= !sclk ? lo_r + {15'h0, lo_r != 16'hffff} : 16'h0;
         st_r <= strobe ? st_r + {15'h0, st_r != 16'hffff} : 16'h0;
      end
   end
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   strobe_quiet_a: assert property (strobe |-> !sclk && !sdata)
      else $error("clock or data high while strobe high");
   word_length_a: assert property ($rose(strobe) |-> bits_r == 5'h18)
      else $error("strobe after a word not 24 bits long");
   bit_limit_a: assert property (bits_r <= 5'h18)
      else $error("more than 24 bits before strobe");
   clock_high_a: assert property ($fell(sclk) |-> hi_r == HALF_CYC)
      else $error("serial clock high phase wrong length");
   clock_low_a: assert property ($rose(sclk) |-> lo_r >= HALF_CYC)
      else $error("serial clock low phase too short");
   data_hold_a: assert property (sclk && $past(sclk) |-> $stable(sdata))
      else $error("data changed while serial clock high");
   strobe_len_a: assert property ($fell(strobe) |-> st_r == STRB_CYC)
      else $error("strobe pulse wrong length");
   strobe_setup_a: assert property ($rose(strobe) |-> lo_r == HALF_CYC && !sdata)
      else $error("strobe rose without quiet clock and data");
   post_quiet_a: assert property ($fell(strobe) |-> (!sclk && !strobe) [*3])
      else $error("link not quiet after strobe");
endmodule // scwl_sva

// [testbench/serial_control_word_loader_test.sv]
// self-checking bench: ahb-lite master drives the host end, which programs the device end
// assumes the rtl ends and the link checker are compiled before this file
`timescale 1ns/1ps
module serial_control_word_loader_test;
   import scwl_pkg::*;
   localparam int HC = 3;
   localparam int SC = 3;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, bank_sel, blocks_powered, tx_mod_enable, oscillator_enable, loop_enable;
   logic [1:0] amp_level;
   logic [31:0] hrdata, rd;
   logic [TUNE_W-1:0] tuning_value;
   logic [7:0] fsk_shift;
   logic [2:0] acquisition_boost_factor;
   logic feedback_divide_select, modulation_select, test_mode;
   logic [23:0] wf0, wf1, wc0, wc1;
   int err_count = 0;
   int num_checks = 0;
   int cyc = 0;
   scwl_if link();
   scwl_host #(.HALF_CYC(HC), .STRB_CYC(SC)) i_scwl_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .hwrite(hwrite), .htrans(htrans), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(link));
   scwl_device i_scwl_device (.hclk(hclk), .hresetn(hresetn), .link(link), .bank_sel(bank_sel),
      .blocks_powered(blocks_powered), .amp_level(amp_level), .tx_mod_enable(tx_mod_enable),
      .oscillator_enable(oscillator_enable), .loop_enable(loop_enable), .tuning_value(tuning_value),
      .fsk_shift(fsk_shift), .acquisition_boost_factor(acquisition_boost_factor),
      .feedback_divide_select(feedback_divide_select), .modulation_select(modulation_select),
      .test_mode(test_mode));
   scwl_sva #(.HALF_CYC(HC), .STRB_CYC(SC)) i_scwl_sva (.hclk(hclk), .hresetn(hresetn), .sclk(link.sclk),
      .sdata(link.sdata), .strobe(link.strobe), .mode_pin(link.mode_pin), .sleep_pin(link.sleep_pin));
   always #2 hclk = ~hclk;
   task automatic print_verdict();
      if (err_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge hclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         err_count++;
         print_verdict();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one single transfer; entered just after a rising edge
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk("hresp", hresp, 32'h0);
   endtask
   task automatic idle();
      repeat (2) @(posedge hclk);
      rd = 32'h1;
      while (rd[STAT_BUSY_BIT] !== 1'b0)
         xfer(REG_STATUS, 1'b0, 32'h0);
      repeat (2) @(posedge hclk);
   endtask
   task automatic send(input logic [23:0] w);
      xfer(REG_WORD, 1'b1, {8'h0, w});
      idle();
   endtask
   task automatic pins(input logic mode, input logic wake);
      xfer(REG_CTRL, 1'b1, {30'h0, wake, mode});
      repeat (4) @(posedge hclk);
      chk("bank_sel", bank_sel, mode);
   endtask
   task automatic bank(input logic [23:0] c, input logic [23:0] f, input logic on);
      chk("amp", amp_level, on ? c[AMP_HI:AMP_LO] : 2'h0);
      chk("txmod", tx_mod_enable, on & (|c[AMP_HI:AMP_LO]));
      chk("osc", oscillator_enable, on & c[OSC_BIT]);
      chk("loop", loop_enable, on & c[LOOP_BIT]);
      chk("tune", tuning_value, f[TUNE_HI:0]);
      chk("power", blocks_powered, on);
      chk("dev", fsk_shift, wc0[DEV_HI:DEV_LO]);
      chk("acc", acquisition_boost_factor, wc1[ACC_HI:ACC_LO]);
      chk("div", feedback_divide_select, wc1[DIV_BIT]);
      chk("modsel", modulation_select, wc1[MOD_BIT]);
   endtask
   initial
   begin
      wf0 = WORD_RST;
      wf1 = WORD_RST;
      wc0 = WORD_RST;
      wc1 = WORD_RST;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bank(wc0, wf0, 1'b0);
      chk("test", test_mode, 1'b0);
      xfer(REG_CTRL, 1'b0, 32'h0);
      chk("ctrl", rd, {30'h0, CTRL_RST});
      send(TEST_CLEAR_WORD);
      chk("test", test_mode, 1'b0);
      xfer(8'h0c, 1'b0, 32'h0);
      chk("unmapped", rd, 32'h0);
      wf0 = {ADDR_FREQ0, 21'h0abcde};
      wf1 = {ADDR_FREQ1, 21'h1f1234};
      wc0 = {ADDR_CTRL0, 8'h5a, 4'he, 9'h0};
      wc1 = {ADDR_CTRL1, 3'h5, 2'h2, 3'h0, 4'h5, 9'h0};
      // second word write stalls until the first has gone out
      xfer(REG_WORD, 1'b1, {8'h0, wf0});
      xfer(REG_WORD, 1'b1, {8'h0, wf1});
      xfer(REG_STATUS, 1'b0, 32'h0);
      chk("busy", rd[STAT_BUSY_BIT], 1'b1);
      xfer(REG_WORD, 1'b0, 32'h0);
      chk("word", rd, {8'h0, wf1});
      idle();
      xfer(REG_WORD, 1'b1, {8'h0, wc0});
      repeat (40) @(posedge hclk);
      chk("dev", fsk_shift, 8'h0);
      idle();
      send(wc1);
      pins(1'b0, 1'b1);
      bank(wc0, wf0, 1'b1);
      pins(1'b1, 1'b1);
      bank(wc1, wf1, 1'b1);
      pins(1'b1, 1'b0);
      bank(wc1, wf1, 1'b0);
      wc1[AMP_HI:AMP_LO] = 2'h3;
      send(wc1);
      pins(1'b1, 1'b1);
      bank(wc1, wf1, 1'b1);
      send({3'h4, 21'h1fffff});
      bank(wc1, wf1, 1'b1);
      pins(1'b0, 1'b1);
      for (int a = 0; a < 4; a++)
      begin
         wc0[AMP_HI:AMP_LO] = a[1:0];
         send(wc0);
         bank(wc0, wf0, 1'b1);
      end
      send({ADDR_TEST, 21'h100000});
      chk("test", test_mode, 1'b1);
      send(TEST_CLEAR_WORD);
      chk("test", test_mode, 1'b0);
      send({ADDR_TEST, 21'h000001});
      chk("test", test_mode, 1'b1);
      bank(wc0, wf0, 1'b1);
      print_verdict();
   end
endmodule // serial_control_word_loader_test
